// file: rtl/iobtc_processor_end.sv
// Processor end: transfer pulses, interrupt facility, data break control
`timescale 1ns/1ps
`include "iobtc_cfg.svh"
module iobtc_processor_end (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus side
  iobtc_bus_if.cpu bus,
  // Instruction sequencing from the processor core
  input wire logic instr_start_i,
  input wire logic [`IOBTC_W-1:0] instr_i,
  input wire logic [`IOBTC_W-1:0] ac_i,
  input wire logic instr_end_i,
  input wire logic [`IOBTC_W-1:0] pc_i,
  input wire logic alt_mode_i,
  // Results back to the core
  output logic pause_o,
  output logic hold_o,
  output logic iot_done_o,
  output logic skip_o,
  output logic ac_load_o,
  output logic [`IOBTC_W-1:0] ac_data_o,
  output logic int_enable_o,
  output logic pc_load_o,
  output logic [`IOBTC_W-1:0] pc_new_o,
  // Core memory port, read data one cycle after a read
  output logic mem_en_o,
  output logic mem_we_o,
  output logic [`IOBTC_W-1:0] mem_addr_o,
  output logic [`IOBTC_W-1:0] mem_wdata_o,
  input wire logic [`IOBTC_W-1:0] mem_rdata_i
);

  iobtc_pkg::iobtc_cpu_t r;
  iobtc_pkg::iobtc_cpu_t n;
  logic is_iot;
  logic take_brk;
  logic take_int;
  logic [`IOBTC_W-1:0] vec;

  // ----------------------------------------------------------------
  // Decode of the incoming instruction and between-instruction events
  // ----------------------------------------------------------------
  assign is_iot = instr_i[`IOBTC_OP_HI:`IOBTC_OP_LO] == `IOBTC_OP_IOT;
  // Breaks outrank interrupts so a fast device never starves
  assign take_brk = instr_end_i && bus.brk_req;
  assign take_int = instr_end_i && !bus.brk_req && r.int_en && bus.int_req;
  assign vec = alt_mode_i ? `IOBTC_VEC_ALT : `IOBTC_VEC_NATIVE;

  // ----------------------------------------------------------------
  // Bus drive
  // ----------------------------------------------------------------
  // Selection code and sub bits stay latched for the whole transfer
  assign bus.dev_sel = r.instr[`IOBTC_SEL_HI:`IOBTC_SEL_LO];
  assign bus.sub_bits = r.instr[`IOBTC_SUB_HI:0];
  assign bus.pulse = r.pulse;
  assign bus.data_to_dev = r.ac;
  assign bus.brk_en = r.brk_en;
  assign bus.brk_done = r.brk_done;
  assign bus.brk_rdata = r.brk_rdata;
  assign bus.wc_ovf = r.wc_ovf;

  // ----------------------------------------------------------------
  // Outputs to the core
  // ----------------------------------------------------------------
  // Hold is combinational so the core stalls in the cycle it ends
  assign hold_o = (r.state != iobtc_pkg::ST_IDLE) || take_brk || take_int;
  assign pause_o = r.pause;
  assign iot_done_o = r.done;
  assign skip_o = r.skip;
  assign ac_load_o = r.ac_load;
  assign ac_data_o = r.ac_data;
  assign int_enable_o = r.int_en;
  assign pc_load_o = r.pc_load;
  assign pc_new_o = r.pc_new;
  assign mem_en_o = r.mem_en;
  assign mem_we_o = r.mem_we;
  assign mem_addr_o = r.mem_addr;
  assign mem_wdata_o = r.mem_wdata;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic [`IOBTC_W-1:0] sum;
    sum = mem_rdata_i + `IOBTC_ONE;
    n = r;
    n.done = 1'b0;
    n.ac_load = 1'b0;
    n.pc_load = 1'b0;
    n.mem_en = 1'b0;
    n.mem_we = 1'b0;
    n.brk_done = 1'b0;
    unique case (r.state)
      iobtc_pkg::ST_IDLE: begin
        if (instr_start_i && is_iot) begin
          // Pause holds time state five until all three pulses pass
          n.pause = 1'b1;
          n.instr = instr_i;
          n.ac = ac_i;
          n.skip = 1'b0;
          n.pulse = 3'h0;
          n.pulse[`IOBTC_P1] = instr_i[`IOBTC_P1];
          n.state = iobtc_pkg::ST_P1;
        end else if (take_brk) begin
          // Same bus serves break and program devices alike
          n.brk_en = 1'b1;
          n.addr = bus.brk_addr;
          n.three = bus.brk_three;
          n.to_mem = bus.brk_to_mem;
          n.ca_inc = bus.brk_ca_inc;
          n.wc_ovf = 1'b0;
          n.phase = bus.brk_three ? iobtc_pkg::PH_WC : iobtc_pkg::PH_DATA;
          n.state = iobtc_pkg::ST_BRD;
        end else if (take_int) begin
          n.int_en = 1'b0;
          n.mem_en = 1'b1;
          n.mem_we = 1'b1;
          n.mem_addr = vec;
          n.mem_wdata = pc_i;
          n.pc_new = vec + `IOBTC_ONE;
          n.pc_load = 1'b1;
          n.state = iobtc_pkg::ST_INT;
        end
      end
      iobtc_pkg::ST_INT: begin
        n.state = iobtc_pkg::ST_IDLE;
      end
      iobtc_pkg::ST_P1: begin
        // Skip counts only when the first pulse really went out
        n.skip = bus.skip && r.instr[`IOBTC_P1];
        n.pulse = 3'h0;
        n.pulse[`IOBTC_P2] = r.instr[`IOBTC_P2];
        n.state = iobtc_pkg::ST_P2;
      end
      iobtc_pkg::ST_P2: begin
        n.pulse = 3'h0;
        n.pulse[`IOBTC_P4] = r.instr[`IOBTC_P4];
        n.state = iobtc_pkg::ST_P4;
      end
      iobtc_pkg::ST_P4: begin
        n.pulse = 3'h0;
        if (r.instr[`IOBTC_P4] && bus.load_ac) begin
          n.ac_data = bus.data_to_cpu;
          n.ac_load = 1'b1;
        end
        if (r.instr == `IOBTC_ION) begin
          n.int_en = 1'b1;
        end else if (r.instr == `IOBTC_IOF) begin
          n.int_en = 1'b0;
        end
        n.pause = 1'b0;
        n.done = 1'b1;
        n.state = iobtc_pkg::ST_IDLE;
      end
      iobtc_pkg::ST_BRD: begin
        n.mem_en = 1'b1;
        n.mem_addr = r.addr;
        // A write into memory needs no read first
        if (r.phase == iobtc_pkg::PH_DATA && r.to_mem) begin
          n.mem_we = 1'b1;
          n.mem_wdata = bus.brk_wdata;
          n.state = iobtc_pkg::ST_BEND;
        end else begin
          n.state = iobtc_pkg::ST_BWT;
        end
      end
      iobtc_pkg::ST_BWT: begin
        n.state = iobtc_pkg::ST_BUSE;
      end
      iobtc_pkg::ST_BUSE: begin
        unique case (r.phase)
          iobtc_pkg::PH_WC: begin
            // Word count runs up from its complement to zero
            n.mem_en = 1'b1;
            n.mem_we = 1'b1;
            n.mem_addr = r.addr;
            n.mem_wdata = sum;
            n.wc_ovf = sum == `IOBTC_ZERO;
            n.addr = r.addr + `IOBTC_ONE;
            n.phase = iobtc_pkg::PH_CA;
            n.state = iobtc_pkg::ST_BRD;
          end
          iobtc_pkg::PH_CA: begin
            n.mem_en = 1'b1;
            n.mem_we = 1'b1;
            n.mem_addr = r.addr;
            n.mem_wdata = r.ca_inc ? sum : mem_rdata_i;
            n.addr = r.ca_inc ? sum : mem_rdata_i;
            n.phase = iobtc_pkg::PH_DATA;
            n.state = iobtc_pkg::ST_BRD;
          end
          iobtc_pkg::PH_DATA: begin
            n.brk_rdata = mem_rdata_i;
            n.state = iobtc_pkg::ST_BEND;
          end
          default: begin
            n.state = iobtc_pkg::ST_BEND;
          end
        endcase
      end
      iobtc_pkg::ST_BEND: begin
        n.brk_en = 1'b0;
        n.brk_done = 1'b1;
        n.state = iobtc_pkg::ST_IDLE;
      end
      default: begin
        n.state = iobtc_pkg::ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register, frozen while the clock enable is low
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

endmodule

// file: rtl/iobtc_cfg.svh
// Constants shared by both ends of the I/O bus transfer control
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`ifndef IOBTC_CFG_SVH
`define IOBTC_CFG_SVH

// ----------------------------------------------------------------
// Widths and instruction fields
// ----------------------------------------------------------------
`define IOBTC_W 12
`define IOBTC_OP_HI 11
`define IOBTC_OP_LO 9
`define IOBTC_SEL_HI 8
`define IOBTC_SEL_LO 3
`define IOBTC_SUB_HI 2
`define IOBTC_OP_IOT 3'h6

// ----------------------------------------------------------------
// Timing pulse positions on the pulse lines
// ----------------------------------------------------------------
`define IOBTC_P1 0
`define IOBTC_P2 1
`define IOBTC_P4 2

// ----------------------------------------------------------------
// Processor-internal transfer instructions and vectors
// ----------------------------------------------------------------
`define IOBTC_ION 12'hc01
`define IOBTC_IOF 12'hc02
`define IOBTC_VEC_NATIVE 12'h000
`define IOBTC_VEC_ALT 12'h020
`define IOBTC_ONE 12'h001
`define IOBTC_ZERO 12'h000

// Default selection code of the peripheral end (arbitrary value)
`define IOBTC_DEV_CODE 6'h0c

`endif

// file: rtl/iobtc_pkg.sv
// Types shared by both ends of the I/O bus transfer control
`include "iobtc_cfg.svh"
package iobtc_pkg;

  // ----------------------------------------------------------------
  // Processor end sequencing
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_P1, ST_P2, ST_P4, ST_INT, ST_BRD, ST_BWT, ST_BUSE, ST_BEND
  } iobtc_state_t;

  typedef enum logic [1:0] {PH_WC, PH_CA, PH_DATA} iobtc_phase_t;

  typedef struct packed {
    iobtc_state_t state;
    iobtc_phase_t phase;
    logic pause;
    logic [`IOBTC_W-1:0] instr;
    logic [`IOBTC_W-1:0] ac;
    logic [2:0] pulse;
    logic skip;
    logic done;
    logic ac_load;
    logic [`IOBTC_W-1:0] ac_data;
    logic int_en;
    logic pc_load;
    logic [`IOBTC_W-1:0] pc_new;
    logic mem_en;
    logic mem_we;
    logic [`IOBTC_W-1:0] mem_addr;
    logic [`IOBTC_W-1:0] mem_wdata;
    logic brk_en;
    logic brk_done;
    logic three;
    logic to_mem;
    logic ca_inc;
    logic wc_ovf;
    logic [`IOBTC_W-1:0] addr;
    logic [`IOBTC_W-1:0] brk_rdata;
  } iobtc_cpu_t;

  // ----------------------------------------------------------------
  // Peripheral end state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic flag;
    logic [`IOBTC_W-1:0] rx_data;
    logic rx_load;
    logic busy;
    logic three;
    logic to_mem;
    logic [`IOBTC_W-1:0] addr;
    logic [`IOBTC_W-1:0] count;
    logic [`IOBTC_W-1:0] rdata;
    logic word;
    logic done;
  } iobtc_dev_t;

endpackage

// file: rtl/iobtc_bus_if.sv
// I/O bus between the processor end and one peripheral end
`timescale 1ns/1ps
`include "iobtc_cfg.svh"
interface iobtc_bus_if;
  // Program-controlled transfer lines
  logic [5:0] dev_sel;
  logic [2:0] sub_bits;
  logic [2:0] pulse;
  logic [`IOBTC_W-1:0] data_to_dev;
  logic [`IOBTC_W-1:0] data_to_cpu;
  logic load_ac;
  logic skip;
  logic int_req;
  // Data break lines
  logic brk_req;
  logic brk_three;
  logic brk_to_mem;
  logic brk_ca_inc;
  logic [`IOBTC_W-1:0] brk_addr;
  logic [`IOBTC_W-1:0] brk_wdata;
  logic brk_en;
  logic brk_done;
  logic [`IOBTC_W-1:0] brk_rdata;
  logic wc_ovf;

  modport cpu (
    output dev_sel, sub_bits, pulse, data_to_dev, brk_en, brk_done, brk_rdata, wc_ovf,
    input data_to_cpu, load_ac, skip, int_req, brk_req, brk_three, brk_to_mem,
    input brk_ca_inc, brk_addr, brk_wdata
  );

  modport dev (
    input dev_sel, sub_bits, pulse, data_to_dev, brk_en, brk_done, brk_rdata, wc_ovf,
    output data_to_cpu, load_ac, skip, int_req, brk_req, brk_three, brk_to_mem,
    output brk_ca_inc, brk_addr, brk_wdata
  );
endinterface

// file: rtl/iobtc_peripheral_end.sv
// Peripheral end: selection decode, flag, data register, break source
`timescale 1ns/1ps
`include "iobtc_cfg.svh"
module iobtc_peripheral_end #(
  parameter logic [5:0] DEV_CODE = `IOBTC_DEV_CODE
) (
  // Clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Bus side
  iobtc_bus_if.dev bus,
  // Program-controlled user side
  input wire logic flag_set_i,
  input wire logic [`IOBTC_W-1:0] tx_data_i,
  output logic flag_o,
  output logic [`IOBTC_W-1:0] rx_data_o,
  output logic rx_load_o,
  output logic [2:0] sub_strobe_o,
  // Block transfer user side
  input wire logic blk_start_i,
  input wire logic blk_three_i,
  input wire logic blk_to_mem_i,
  input wire logic [`IOBTC_W-1:0] blk_addr_i,
  input wire logic [`IOBTC_W-1:0] blk_count_i,
  input wire logic [`IOBTC_W-1:0] blk_wdata_i,
  output logic blk_busy_o,
  output logic blk_word_o,
  output logic [`IOBTC_W-1:0] blk_rdata_o,
  output logic blk_done_o
);

  iobtc_pkg::iobtc_dev_t r;
  iobtc_pkg::iobtc_dev_t n;
  logic [2:0] gated;

  // ----------------------------------------------------------------
  // Selection decode and bus drive
  // ----------------------------------------------------------------
  // Pulses for other codes never reach our logic
  assign gated = (bus.dev_sel == DEV_CODE) ? bus.pulse : 3'h0;
  assign sub_strobe_o = gated & bus.sub_bits;
  assign bus.skip = gated[`IOBTC_P1] & r.flag;
  assign bus.load_ac = gated[`IOBTC_P4];
  assign bus.data_to_cpu = tx_data_i;
  assign bus.int_req = r.flag;
  assign bus.brk_req = r.busy;
  assign bus.brk_three = r.three;
  assign bus.brk_to_mem = r.to_mem;
  assign bus.brk_ca_inc = 1'b1;
  assign bus.brk_addr = r.addr;
  assign bus.brk_wdata = blk_wdata_i;

  // Outputs straight from state
  assign flag_o = r.flag;
  assign rx_data_o = r.rx_data;
  assign rx_load_o = r.rx_load;
  assign blk_busy_o = r.busy;
  assign blk_word_o = r.word;
  assign blk_rdata_o = r.rdata;
  assign blk_done_o = r.done;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.rx_load = 1'b0;
    n.word = 1'b0;
    n.done = 1'b0;
    // Set wins over a clear in the same cycle
    if (flag_set_i) begin
      n.flag = 1'b1;
    end else if (gated[`IOBTC_P2]) begin
      n.flag = 1'b0;
    end
    if (gated[`IOBTC_P4]) begin
      n.rx_data = bus.data_to_dev;
      n.rx_load = 1'b1;
    end
    if (!r.busy && blk_start_i) begin
      n.busy = 1'b1;
      n.three = blk_three_i;
      n.to_mem = blk_to_mem_i;
      n.addr = blk_addr_i;
      n.count = blk_count_i;
    end else if (r.busy && bus.brk_done) begin
      n.word = 1'b1;
      n.rdata = bus.brk_rdata;
      if (r.three) begin
        // Memory keeps the count; overflow ends the block
        if (bus.wc_ovf) begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end else begin
        n.addr = r.addr + `IOBTC_ONE;
        n.count = r.count - `IOBTC_ONE;
        if (r.count == `IOBTC_ONE) begin
          n.busy = 1'b0;
          n.done = 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      r <= '0;
    end else if (ce_i) begin
      r <= n;
    end
  end

endmodule

// file: test/iobtc_asserts.sv
// Concurrent checks on the I/O bus joining the two ends
`timescale 1ns/1ps
`include "iobtc_cfg.svh"
module iobtc_asserts #(
  parameter logic [5:0] DEV_CODE = `IOBTC_DEV_CODE
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_i,
  // Bus signals watched
  input wire logic [5:0] dev_sel_i,
  input wire logic [2:0] sub_bits_i,
  input wire logic [2:0] pulse_i,
  input wire logic skip_i,
  input wire logic load_ac_i,
  input wire logic brk_req_i,
  input wire logic brk_en_i,
  input wire logic brk_done_i
);
  // ----------------------------------------------------------------
  // Shared clocking and sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (rst_i);

  // After weight one, weight one is quiet next cycle, then weights one and two both quiet the cycle after
  sequence s_after_wt1;
    !pulse_i[0] ##1 ((pulse_i & 3'h3) == 3'h0);
  endsequence

  // Grant covers at least the address and data cycles
  sequence s_grant_held;
    brk_en_i [*2];
  endsequence

  // ----------------------------------------------------------------
  // Program-controlled transfers
  // ----------------------------------------------------------------
  pulse_onehot_a: assert property ($onehot0(pulse_i))
    else $error("two timing pulses at once");
  pulse_order_a: assert property (pulse_i[0] |=> s_after_wt1)
    else $error("timing pulses out of order");
  pulse_gated_a: assert property ((pulse_i & ~sub_bits_i) == 3'h0)
    else $error("unselected timing pulse on bus");
  sel_stable_a: assert property ((|pulse_i && |$past(pulse_i)) |-> $stable(dev_sel_i))
    else $error("selection code moved inside a transfer");
  skip_on_wt1_a: assert property (skip_i |-> pulse_i[0] && dev_sel_i == DEV_CODE)
    else $error("skip outside selected first pulse");
  load_on_wt4_a: assert property (load_ac_i |-> pulse_i[2] && dev_sel_i == DEV_CODE)
    else $error("word load outside selected last pulse");

  // ----------------------------------------------------------------
  // Data break
  // ----------------------------------------------------------------
  grant_needs_req_a: assert property ($rose(brk_en_i) |->
    $past(brk_req_i) && brk_req_i)
    else $error("break granted without request");
  grant_held_a: assert property ($rose(brk_en_i) |-> s_grant_held)
    else $error("break grant dropped early");
  break_bounded_a: assert property ($rose(brk_en_i) |-> ##[2:10] brk_done_i)
    else $error("break did not finish in time");
  done_pulse_a: assert property (brk_done_i |-> $past(brk_en_i) ##1 !brk_done_i)
    else $error("break done without grant or too long");
endmodule

// file: test/test_io_bus_transfer_control.sv
// Self-checking bench joining processor end and peripheral end
`timescale 1ns/1ps
`include "iobtc_cfg.svh"
module test_io_bus_transfer_control;
  localparam logic [5:0] DEV = 6'h0c; // Arbitrary selection code
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic instr_start_i = 1'b0, instr_end_i = 1'b0, alt_mode_i = 1'b0;
  logic flag_set_i = 1'b0, blk_start_i = 1'b0, blk_three_i = 1'b0, blk_to_mem_i = 1'b0;
  logic [11:0] instr_i = 12'h000, ac_i = 12'h000, pc_i = 12'h000, mem_rdata_i = 12'h000;
  logic [11:0] tx_data_i = 12'h000, blk_addr_i = 12'h000, blk_count_i = 12'h000;
  logic [11:0] blk_wdata_i = 12'h000;
  logic pause_o, hold_o, iot_done_o, skip_o, ac_load_o, int_enable_o, pc_load_o;
  logic mem_en_o, mem_we_o, flag_o, rx_load_o, blk_busy_o, blk_word_o, blk_done_o;
  logic [11:0] ac_data_o, pc_new_o, mem_addr_o, mem_wdata_o, rx_data_o, blk_rdata_o;
  logic [2:0] sub_strobe_o;
  logic [11:0] mem [0:4095];
  logic [15:0] lfsr = 16'h004c;
  logic exp_flag = 1'b0;
  logic [1:0] saw = 2'h0;
  int err_total = 0;
  int n_tests = 0;

  // ----------------------------------------------------------------
  // Design, bus and checker
  // ----------------------------------------------------------------
  iobtc_bus_if bus ();
  iobtc_processor_end i_iobtc_processor_end (.clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .bus(bus), .instr_start_i(instr_start_i), .instr_i(instr_i), .ac_i(ac_i),
    .instr_end_i(instr_end_i), .pc_i(pc_i), .alt_mode_i(alt_mode_i), .pause_o(pause_o),
    .hold_o(hold_o), .iot_done_o(iot_done_o), .skip_o(skip_o), .ac_load_o(ac_load_o),
    .ac_data_o(ac_data_o), .int_enable_o(int_enable_o), .pc_load_o(pc_load_o),
    .pc_new_o(pc_new_o), .mem_en_o(mem_en_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
    .mem_wdata_o(mem_wdata_o), .mem_rdata_i(mem_rdata_i));
  iobtc_peripheral_end #(.DEV_CODE(DEV)) i_iobtc_peripheral_end (.clock_i(clock_i),
    .rst_i(rst_i), .ce_i(1'b1), .bus(bus), .flag_set_i(flag_set_i), .tx_data_i(tx_data_i),
    .flag_o(flag_o), .rx_data_o(rx_data_o), .rx_load_o(rx_load_o),
    .sub_strobe_o(sub_strobe_o), .blk_start_i(blk_start_i), .blk_three_i(blk_three_i),
    .blk_to_mem_i(blk_to_mem_i), .blk_addr_i(blk_addr_i), .blk_count_i(blk_count_i),
    .blk_wdata_i(blk_wdata_i), .blk_busy_o(blk_busy_o), .blk_word_o(blk_word_o),
    .blk_rdata_o(blk_rdata_o), .blk_done_o(blk_done_o));
  iobtc_asserts #(.DEV_CODE(DEV)) i_iobtc_asserts (.clock_i(clock_i), .rst_i(rst_i),
    .dev_sel_i(bus.dev_sel), .sub_bits_i(bus.sub_bits), .pulse_i(bus.pulse),
    .skip_i(bus.skip), .load_ac_i(bus.load_ac), .brk_req_i(bus.brk_req),
    .brk_en_i(bus.brk_en), .brk_done_i(bus.brk_done));

  // 50 MHz clock
  always #10 clock_i = ~clock_i;

  // Core memory: synchronous read, one cycle of latency
  always @(posedge clock_i) begin
    if (mem_en_o && mem_we_o) begin
      mem[mem_addr_o] <= mem_wdata_o;
    end
    mem_rdata_i <= mem[mem_addr_o];
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Inputs move 1 ns after the edge so sampling never races
  task automatic step();
    @(posedge clock_i);
    #1;
  endtask

  task automatic chk(input logic [11:0] got, input logic [11:0] want);
    n_tests++;
    if (got !== want) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask

  task automatic print_verdict();
    $display("totals: tests=%0d mismatches=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic set_flag();
    flag_set_i = 1'b1;
    step();
    flag_set_i = 1'b0;
    exp_flag = 1'b1;
  endtask

  // One transfer instruction, pulses watched cycle by cycle
  task automatic do_iot(input logic [11:0] ins, input logic [11:0] acc);
    logic [2:0] seen;
    logic hit;
    logic fl;
    int n;
    seen = 3'h0;
    hit = (ins[8:3] == DEV);
    fl = exp_flag;
    instr_start_i = 1'b1;
    instr_i = ins;
    ac_i = acc;
    step();
    instr_start_i = 1'b0;
    n = 0;
    while (iot_done_o !== 1'b1 && n < 10) begin
      seen = seen | bus.pulse;
      chk(pause_o, 1'b1);
      chk(bus.pulse, ins[2:0] & (3'h1 << n));
      chk(sub_strobe_o, hit ? ins[2:0] & (3'h1 << n) : 3'h0);
      if (|bus.pulse) chk(bus.dev_sel, ins[8:3]);
      step();
      n++;
    end
    if (n >= 10) begin
      err_total++;
      print_verdict();
    end
    chk(n[11:0], 12'h003);
    chk(seen, ins[2:0]);
    chk(skip_o, hit & ins[0] & fl);
    chk(ac_load_o, hit & ins[2]);
    chk(rx_load_o, hit & ins[2]);
    if (hit && ins[2]) begin
      chk(ac_data_o, tx_data_i);
      chk(rx_data_o, acc);
    end
    if (hit && ins[1]) exp_flag = 1'b0;
    chk(flag_o, exp_flag);
  endtask

  // Instruction boundary, then room for any stolen cycles
  task automatic gap(input logic [11:0] pc);
    instr_end_i = 1'b1;
    pc_i = pc;
    step();
    instr_end_i = 1'b0;
    // Word and done are one-cycle pulses, so collect them as they pass
    repeat (12) begin
      step();
      saw = saw | {blk_word_o, blk_done_o};
    end
  endtask

  task automatic do_brk(input logic three, input logic to_mem, input logic [11:0] a,
                        input logic [11:0] w);
    int n;
    blk_start_i = 1'b1;
    blk_three_i = three;
    blk_to_mem_i = to_mem;
    blk_addr_i = a;
    blk_count_i = 12'h001;
    blk_wdata_i = w;
    step();
    blk_start_i = 1'b0;
    repeat (4) step();
    chk(bus.brk_req, 1'b1);
    chk(bus.brk_en, 1'b0);
    n = 0;
    saw = 2'h0;
    while (blk_busy_o === 1'b1 && n < 6) begin
      gap(a);
      n++;
    end
    chk(saw, 2'h3);
    if (blk_busy_o !== 1'b0) begin
      err_total++;
      print_verdict();
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [11:0] a, ca, w, v, t, pc, vec;
    logic [5:0] sel;
    repeat (16) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    // Random transfers across all eight pulse selections
    for (int i = 0; i < 24; i++) begin
      lfsr = lfsr_next(lfsr);
      sel = lfsr[0] ? DEV : (lfsr[8:3] | 6'h01);
      tx_data_i = lfsr[15:4];
      if (lfsr[1]) set_flag();
      do_iot({3'h6, sel, i[2:0]}, {lfsr[3:0], lfsr[15:8]});
    end
    // Opcode other than six must stay silent
    instr_start_i = 1'b1;
    instr_i = 12'ha31;
    step();
    instr_start_i = 1'b0;
    repeat (5) begin
      chk(bus.pulse, 3'h0);
      chk(pause_o, 1'b0);
      step();
    end
    // Breaks: single and three-cycle, both directions
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      a = {2'h2, lfsr[9:0]};
      ca = {2'h3, lfsr[15:7], 1'b0};
      w = lfsr[11:0];
      v = ~lfsr[11:0];
      mem[a] = i[1] ? 12'hfff : v;
      mem[a + 12'h001] = ca;
      mem[ca + 12'h001] = v;
      do_brk(i[1], i[0], a, w);
      if (i[1]) begin
        chk(mem[a], 12'h000);
        chk(mem[a + 12'h001], ca + 12'h001);
        chk(bus.wc_ovf, 1'b1);
      end
      t = i[1] ? ca + 12'h001 : a;
      if (i[0]) chk(mem[t], w);
      else chk(blk_rdata_o, v);
    end
    // Enable on and off, a refused boundary, then a taken interrupt, in both modes
    for (int m = 0; m < 2; m++) begin
      set_flag();
      do_iot(12'hc01, 12'h000);
      chk(int_enable_o, 1'b1);
      do_iot(12'hc02, 12'h000);
      chk(int_enable_o, 1'b0);
      lfsr = lfsr_next(lfsr);
      pc = {1'b1, lfsr[10:0]};
      vec = m[0] ? 12'h020 : 12'h000;
      alt_mode_i = m[0];
      instr_end_i = 1'b1;
      pc_i = pc;
      step();
      instr_end_i = 1'b0;
      chk(pc_load_o, 1'b0);
      do_iot(12'hc01, 12'h000);
      instr_end_i = 1'b1;
      step();
      instr_end_i = 1'b0;
      chk(hold_o, 1'b1);
      chk(pc_load_o, 1'b1);
      chk(pc_new_o, vec + 12'h001);
      chk(int_enable_o, 1'b0);
      repeat (3) step();
      chk(hold_o, 1'b0);
      chk(mem[vec], pc);
    end
    print_verdict();
  end
endmodule
